// file: dv/word_compare_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module word_compare_unit_tb_top import word_compare_pkg::*; ;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata, mem_rdata, mem_wdata;
   logic [ADDR_W-1:0] mem_addr;
   logic mem_rd, mem_wr, greater_flag, equal_flag, less_flag, error_flag, irq;
   int failures = 0;
   int cmp_count = 0;
   integer seed = 32'h04ec620b;
   logic [15:0] rd, a, b, s, t, u;
   logic [31:0] x, y;
   logic [2:0] f;
   always #12.5 core_clk = ~core_clk;
   word_compare_unit dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .greater_flag(greater_flag),
      .equal_flag(equal_flag), .less_flag(less_flag), .error_flag(error_flag), .irq(irq));
   word_memory_model mem_u (.core_clk(core_clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   task automatic reg_write(input logic [3:0] ad, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] ad);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task automatic run(input op_t op, input logic [15:0] mode);
      int n;
      reg_write(REG_CMD, {13'h0000, op} | 16'h0008 | mode);
      n = 0;
      rd = 16'h0010;
      while (rd[FLG_BUSY] !== 1'b0 && n < 200) begin
         reg_read(REG_FLAGS);
         n++;
      end
      `CHK("idle", 1'b0, rd[FLG_BUSY])
      repeat (2) @(posedge core_clk);
   endtask
   function automatic logic [2:0] exp_cmp(input logic [31:0] p, input logic [31:0] q);
      return (p > q) ? 3'b001 : (p == q) ? 3'b010 : 3'b100;
   endfunction
   function automatic logic [15:0] exp_word(input op_t op, input logic [15:0] src);
      logic [15:0] r;
      for (int n = 0; n < 16; n++) begin
         case (op)
            OP_RANGE: r[n] = mem_u.words[64+2*n] <= src && src <= mem_u.words[65+2*n];
            OP_TABLE: r[n] = mem_u.words[128+n] == src;
            default: r[n] = mem_u.words[160+n] != mem_u.words[192+n];
         endcase
      end
      return r;
   endfunction
   task automatic word_test(input op_t op, input logic [15:0] src);
      logic [15:0] e;
      e = exp_word(op, src);
      run(op, 16'h0000);
      reg_read(REG_RESULT);
      `CHK("result reg", e, rd)
      `CHK("result word", e, mem_u.words[250])
      `CHK("zero result", e == 16'h0000, equal_flag)
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #1500000;
      failures++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      reg_write(REG_OP1, 16'd10);
      reg_write(REG_OP2, 16'd11);
      reg_write(REG_RES_ADDR, 16'd250);
      for (int i = 0; i < 12; i++) begin
         a = 16'($random(seed));
         b = (i % 4 == 0) ? a : 16'($random(seed));
         // Would order the other way if the compare were signed.
         if (i == 1) begin
            a = 16'h8000;
            b = 16'h7fff;
         end
         mem_u.words[10] = a;
         mem_u.words[11] = b;
         run(i % 2 ? OP_SINGLE_NI : OP_SINGLE, 16'h0000);
         `CHK("single", exp_cmp({16'h0, a}, {16'h0, b}), {less_flag, equal_flag, greater_flag})
      end
      $display("single compare test done");
      reg_write(REG_OP2, 16'd20);
      for (int i = 0; i < 8; i++) begin
         x = 32'($random(seed));
         y = (i % 3 == 0) ? x : 32'($random(seed));
         if (i == 1) y = {x[31:16], ~x[15:0]};
         if (i == 2) y = {~x[31:16], x[15:0]};
         {mem_u.words[11], mem_u.words[10]} = x;
         {mem_u.words[21], mem_u.words[20]} = y;
         run(i % 2 ? OP_DOUBLE_NI : OP_DOUBLE, 16'h0000);
         `CHK("double", exp_cmp(x, y), {less_flag, equal_flag, greater_flag})
      end
      x = 32'($random(seed)) | 32'h80000000;
      {mem_u.words[21], mem_u.words[20]} = x - 32'h1;
      reg_write(REG_IMM1_LO, x[15:0]);
      reg_write(REG_IMM1_HI, x[31:16]);
      run(OP_DOUBLE, 16'h0080);
      `CHK("double imm", 3'b001, {less_flag, equal_flag, greater_flag})
      {mem_u.words[11], mem_u.words[10]} = x - 32'h1;
      reg_write(REG_IMM2_LO, x[15:0]);
      reg_write(REG_IMM2_HI, x[31:16]);
      run(OP_DOUBLE, 16'h0100);
      `CHK("double imm2", 3'b100, {less_flag, equal_flag, greater_flag})
      $display("double compare test done");
      reg_write(REG_OP2, 16'd64);
      for (int i = 0; i < 4; i++) begin
         s = 16'($random(seed));
         mem_u.words[10] = s;
         for (int k = 0; k < 16; k++) begin
            t = 16'($random(seed));
            u = 16'($random(seed));
            {mem_u.words[64+2*k], mem_u.words[65+2*k]} = (t < u) ? {t, u} : {u, t};
            if (k == 2 * i) {mem_u.words[64+2*k], mem_u.words[65+2*k]} = {s, s | u};
            if (k == 2 * i + 1) {mem_u.words[64+2*k], mem_u.words[65+2*k]} = {s & t, s};
            if (i == 3) {mem_u.words[64+2*k], mem_u.words[65+2*k]} = {s + 16'h1, s + 16'h1};
         end
         word_test(OP_RANGE, s);
      end
      reg_write(REG_OP2, 16'd128);
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 16; k++) begin
            mem_u.words[128+k] = (i < 2 && k % 5 == 2 * i) ? s : 16'($random(seed));
         end
         word_test(OP_TABLE, s);
      end
      reg_write(REG_OP1, 16'd160);
      reg_write(REG_OP2, 16'd192);
      for (int i = 0; i < 2; i++) begin
         for (int k = 0; k < 16; k++) begin
            mem_u.words[160+k] = 16'($random(seed));
            mem_u.words[192+k] = (i == 1 || k % 3 == 0) ? mem_u.words[160+k] : 16'($random(seed));
         end
         word_test(OP_PAIR, s);
      end
      $display("result word test done");
      reg_write(REG_OP1, 16'd10);
      reg_write(REG_OP2, 16'd11);
      mem_u.words[10] = 16'h0001;
      mem_u.words[11] = 16'h0002;
      run(OP_SINGLE, 16'h0000);
      mem_u.words[10] = 16'h0005;
      mem_u.words[250] = 16'h5a5a;
      f = {less_flag, equal_flag, greater_flag};
      reg_write(REG_CMD, 16'h0000);
      reg_write(REG_CMD, 16'h0002);
      reg_write(REG_CMD, 16'h000f);
      repeat (80) @(posedge core_clk);
      `CHK("exec off flags", 3'b100, f)
      `CHK("exec off flags", f, {less_flag, equal_flag, greater_flag})
      `CHK("exec off result", 16'h5a5a, mem_u.words[250])
      $display("execution condition test done");
      reg_write(REG_IRQ_MASK, 16'h0002);
      mem_u.words[10] = 16'h0012;
      mem_u.words[12] = 16'h0300;
      mem_u.words[11] = 16'h0013;
      mem_u.words[13] = 16'h0300;
      run(OP_SINGLE, 16'h0070);
      `CHK("bcd pointer", 4'b0010, {error_flag, less_flag, equal_flag, greater_flag})
      `CHK("irq masked", 1'b0, irq)
      mem_u.words[10] = 16'h00a5;
      run(OP_SINGLE, 16'h0030);
      `CHK("bad pointer", 4'b1010, {error_flag, less_flag, equal_flag, greater_flag})
      `CHK("irq raised", 1'b1, irq)
      reg_read(REG_IRQ_STAT);
      `CHK("irq status", 16'h0003, rd)
      reg_write(REG_IRQ_STAT, 16'h0003);
      reg_read(4'hf);
      `CHK("unmapped", 16'h0000, rd)
      `CHK("irq cleared", 1'b0, irq)
      reg_read(REG_IRQ_STAT);
      `CHK("status cleared", 16'h0000, rd)
      mem_u.words[10] = 16'h0301;
      run(OP_SINGLE, 16'h0000);
      `CHK("error cleared", 4'b0001, {error_flag, less_flag, equal_flag, greater_flag})
      `CHK("done masked", 1'b0, irq)
      $display("error and interrupt test done");
      wrap_up();
   end
endmodule

// file: dv/word_memory_model.sv
`timescale 1ns/1ps
module word_memory_model import word_compare_pkg::*; (
   input wire logic core_clk,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [DATA_W-1:0] mem_wdata,
   output logic [DATA_W-1:0] mem_rdata
);
   logic [DATA_W-1:0] words [256];
   logic [DATA_W-1:0] last_q;
   // Zero-latency read; while released the bus shows the inverse of the last word, so stale data never matches.
   assign mem_rdata = mem_rd ? words[mem_addr[7:0]] : ~last_q;
   always @(posedge core_clk) begin
      if (mem_rd) begin
         last_q <= words[mem_addr[7:0]];
      end
   end
   // The bench preloads words directly, so this stays a plain always block.
   always @(posedge core_clk) begin
      if (mem_wr) begin
         words[mem_addr[7:0]] <= mem_wdata;
      end
   end
endmodule

// file: verilog/bcd_pointer.sv
`timescale 1ns/1ps
module bcd_pointer import word_compare_pkg::*; (
   input wire logic [DATA_W-1:0] word,
   output logic [ADDR_W-1:0] addr,
   output logic ok
);
   logic [ADDR_W-1:0] d3;
   logic [ADDR_W-1:0] d2;
   logic [ADDR_W-1:0] d1;
   logic [ADDR_W-1:0] d0;

   assign d3 = {12'h000, word[15:12]};
   assign d2 = {12'h000, word[11:8]};
   assign d1 = {12'h000, word[7:4]};
   assign d0 = {12'h000, word[3:0]};
   assign ok = (word[15:12] <= BCD_MAX_DIGIT) && (word[11:8] <= BCD_MAX_DIGIT) &&
               (word[7:4] <= BCD_MAX_DIGIT) && (word[3:0] <= BCD_MAX_DIGIT);
   assign addr = ADDR_W'(d3 * 16'd1000 + d2 * 16'd100 + d1 * 16'd10 + d0);
endmodule

// file: verilog/magnitude_compare.sv
`timescale 1ns/1ps
module magnitude_compare import word_compare_pkg::*; (
   input wire logic [WIDE_W-1:0] lhs,
   input wire logic [WIDE_W-1:0] rhs,
   output logic gr,
   output logic eq,
   output logic le
);
   // Unsigned ordering also sorts valid BCD words correctly.
   assign gr = lhs > rhs;
   assign eq = lhs == rhs;
   assign le = lhs < rhs;
endmodule

// file: verilog/word_compare_pkg.sv
package word_compare_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int WIDE_W = 32;
   localparam int STEP_W = 6;

   // Opcodes as software writes them into the command register.
   typedef enum logic [2:0] {
      OP_SINGLE    = 3'b000,
      OP_DOUBLE    = 3'b001,
      OP_RANGE     = 3'b010,
      OP_TABLE     = 3'b011,
      OP_PAIR      = 3'b100,
      OP_SINGLE_NI = 3'b101,
      OP_DOUBLE_NI = 3'b110,
      OP_ILLEGAL   = 3'b111
   } op_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_PTR_RD  = 3'b001,
      ST_PTR_CAP = 3'b010,
      ST_FETCH   = 3'b011,
      ST_CAPT    = 3'b100,
      ST_WRITE   = 3'b101,
      ST_DONE    = 3'b110
   } state_t;

   // Register indices on the plain register port.
   localparam logic [3:0] REG_CMD      = 4'h0;
   localparam logic [3:0] REG_OP1      = 4'h1;
   localparam logic [3:0] REG_OP2      = 4'h2;
   localparam logic [3:0] REG_RES_ADDR = 4'h3;
   localparam logic [3:0] REG_IMM1_LO  = 4'h4;
   localparam logic [3:0] REG_IMM1_HI  = 4'h5;
   localparam logic [3:0] REG_IMM2_LO  = 4'h6;
   localparam logic [3:0] REG_IMM2_HI  = 4'h7;
   localparam logic [3:0] REG_FLAGS    = 4'h8;
   localparam logic [3:0] REG_RESULT   = 4'h9;
   localparam logic [3:0] REG_IRQ_STAT = 4'ha;
   localparam logic [3:0] REG_IRQ_MASK = 4'hb;

   // Command register fields.
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_EXEC   = 3;
   localparam int CMD_BCD    = 4;
   localparam int CMD_IND1   = 5;
   localparam int CMD_IND2   = 6;
   localparam int CMD_IMM1   = 7;
   localparam int CMD_IMM2   = 8;
   localparam int CMD_W      = 9;

   // Flag register fields.
   localparam int FLG_GR   = 0;
   localparam int FLG_EQ   = 1;
   localparam int FLG_LE   = 2;
   localparam int FLG_ER   = 3;
   localparam int FLG_BUSY = 4;

   // Interrupt status and mask fields.
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   localparam int IRQ_W    = 2;

   // Operand fetches per operation.
   localparam logic [5:0] STEPS_SINGLE = 6'h02;
   localparam logic [5:0] STEPS_DOUBLE = 6'h04;
   localparam logic [5:0] STEPS_RANGE  = 6'h21;
   localparam logic [5:0] STEPS_TABLE  = 6'h11;
   localparam logic [5:0] STEPS_PAIR   = 6'h20;

   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;

endpackage

// file: verilog/word_compare_unit.sv
`timescale 1ns/1ps
// How it works
// RQ1 - Single compare drives greater, equal, less flags.
// RQ2 - Non-BCD indirect pointer in BCD mode raises error.
// RQ3 - Execution condition off: nothing changes.
// RQ4 - Double compare joins address+1 high, address low.
// RQ5 - Double compare sets exactly one flag.
// RQ6 - Double compare immediates fill both halves.
// RQ7 - Program places intermediate compares mid-line only.
// RQ8 - Program reads flags before later instructions.
// RQ9 - Non-intermediate single and double opcodes offered.
// RQ10 - Program supplies BCD against timer present values.
// RQ11 - Range compare sets bit for inclusive pair.
// RQ12 - Range bits outside their range cleared.
// RQ13 - Program keeps each lower limit below upper.
// RQ14 - Range base avoids last 31 area words.
// RQ15 - Zero result word sets the equal flag.
// RQ16 - Table compare sets bit on equal word.
// RQ17 - Table base avoids last 15 area words.
// RQ18 - Pairwise compare sets bit when words differ.
// RQ19 - Single and double compares are unsigned.
module word_compare_unit import word_compare_pkg::*; (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [DATA_W-1:0] mem_rdata,
   output logic mem_rd,
   output logic mem_wr,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [DATA_W-1:0] mem_wdata,
   output logic greater_flag,
   output logic equal_flag,
   output logic less_flag,
   output logic error_flag,
   output logic irq
);

   state_t state_q;
   op_t op_q;
   logic [CMD_W-1:0] cmd_q;
   logic ptr_sel_q;
   logic [STEP_W-1:0] step_q;
   logic [ADDR_W-1:0] op1_q, op2_q, res_addr_q, base_a_q, base_b_q;
   logic [DATA_W-1:0] imm1_lo_q, imm1_hi_q, imm2_lo_q, imm2_hi_q;
   logic [WIDE_W-1:0] a_val_q, b_val_q;
   logic [DATA_W-1:0] hold_q, result_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_evt;
   logic cmd_wr, start, last_step, imm_now, ptr_ok, cmp_gr, cmp_eq, cmp_le;
   logic [DATA_W-1:0] cap_data, imm_word;
   logic [ADDR_W-1:0] ptr_addr;
   logic [4:0] range_idx;
   logic [STEP_W-1:0] table_idx;

   // Both non-intermediate opcodes behave as their intermediate forms.
   function automatic op_t norm_op(input logic [2:0] code);
      unique case (code)
         OP_SINGLE_NI: norm_op = OP_SINGLE; // see RQ9
         OP_DOUBLE_NI: norm_op = OP_DOUBLE; // see RQ9
         default: norm_op = op_t'(code);
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] addr_of(input op_t op, input logic [STEP_W-1:0] k,
                                                 input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
      addr_of = a;
      unique case (op)
         OP_SINGLE: addr_of = (k == 6'h00) ? a : b;
         OP_DOUBLE: addr_of = (k[1] ? b : a) + {15'h0000, k[0]}; // see RQ4
         OP_RANGE, OP_TABLE: addr_of = (k == 6'h00) ? a : ADDR_W'(b + {10'h000, k} - 16'h0001);
         OP_PAIR: addr_of = (k[0] ? b : a) + {11'h000, k[5:1]};
         default: addr_of = a;
      endcase
   endfunction

   assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
   // A command with the execution condition off is simply dropped.
   assign start = cmd_wr && (state_q == ST_IDLE) && reg_wdata[CMD_EXEC] &&
                  (reg_wdata[CMD_OP_LSB +: 3] != OP_ILLEGAL); // see RQ3
   assign last_step = (step_q == ((op_q == OP_SINGLE) ? STEPS_SINGLE - 6'h01 :
                                  (op_q == OP_DOUBLE) ? STEPS_DOUBLE - 6'h01 :
                                  (op_q == OP_RANGE) ? STEPS_RANGE - 6'h01 :
                                  (op_q == OP_TABLE) ? STEPS_TABLE - 6'h01 : STEPS_PAIR - 6'h01));

   always_comb begin
      imm_now = 1'b0;
      imm_word = imm1_lo_q;
      unique case (op_q)
         OP_SINGLE: begin
            imm_now = (step_q == 6'h00) ? cmd_q[CMD_IMM1] : cmd_q[CMD_IMM2];
            imm_word = (step_q == 6'h00) ? imm1_lo_q : imm2_lo_q;
         end
         OP_DOUBLE: begin
            // Immediates are eight digits wide and fill both halves.
            imm_now = step_q[1] ? cmd_q[CMD_IMM2] : cmd_q[CMD_IMM1]; // see RQ6
            imm_word = step_q[1] ? (step_q[0] ? imm2_hi_q : imm2_lo_q) : (step_q[0] ? imm1_hi_q : imm1_lo_q);
         end
         OP_RANGE, OP_TABLE: imm_now = (step_q == 6'h00) && cmd_q[CMD_IMM1];
         default: imm_now = 1'b0;
      endcase
   end

   assign cap_data = imm_now ? imm_word : mem_rdata;
   assign range_idx = 5'(step_q[5:1] - 5'h01);
   assign table_idx = 6'(step_q - 6'h01);

   magnitude_compare u_cmp (
      .lhs(a_val_q),
      .rhs(b_val_q),
      .gr(cmp_gr),
      .eq(cmp_eq),
      .le(cmp_le)
   );

   bcd_pointer u_ptr (
      .word(mem_rdata),
      .addr(ptr_addr),
      .ok(ptr_ok)
   );

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         ptr_sel_q <= 1'b0;
         step_q <= 6'h00;
      end else begin
         unique case (state_q)
            ST_IDLE: if (start) begin
               ptr_sel_q <= !reg_wdata[CMD_IND1];
               step_q <= 6'h00;
               state_q <= (reg_wdata[CMD_IND1] || reg_wdata[CMD_IND2]) ? ST_PTR_RD : ST_FETCH;
            end
            ST_PTR_RD: state_q <= ST_PTR_CAP;
            ST_PTR_CAP: begin
               if (cmd_q[CMD_BCD] && !ptr_ok) begin
                  state_q <= ST_DONE; // see RQ2
               end else if (!ptr_sel_q && cmd_q[CMD_IND2]) begin
                  ptr_sel_q <= 1'b1;
                  state_q <= ST_PTR_RD;
               end else begin
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: state_q <= ST_CAPT;
            ST_CAPT: begin
               step_q <= 6'(step_q + 6'h01);
               if (!last_step) begin
                  state_q <= ST_FETCH;
               end else begin
                  state_q <= (op_q == OP_SINGLE || op_q == OP_DOUBLE) ? ST_DONE : ST_WRITE;
               end
            end
            ST_WRITE: state_q <= ST_DONE;
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= '0;
         op_q <= OP_SINGLE;
         op1_q <= '0;
         op2_q <= '0;
         res_addr_q <= '0;
         imm1_lo_q <= '0;
         imm1_hi_q <= '0;
         imm2_lo_q <= '0;
         imm2_hi_q <= '0;
         irq_mask_q <= '0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_CMD: if (start) begin
               cmd_q <= reg_wdata[CMD_W-1:0];
               op_q <= norm_op(reg_wdata[CMD_OP_LSB +: 3]);
            end
            REG_OP1: op1_q <= reg_wdata;
            REG_OP2: op2_q <= reg_wdata;
            REG_RES_ADDR: res_addr_q <= reg_wdata;
            REG_IMM1_LO: imm1_lo_q <= reg_wdata;
            REG_IMM1_HI: imm1_hi_q <= reg_wdata;
            REG_IMM2_LO: imm2_lo_q <= reg_wdata;
            REG_IMM2_HI: imm2_hi_q <= reg_wdata;
            REG_IRQ_MASK: irq_mask_q <= reg_wdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Operand bases, replaced by the resolved pointer when indirect.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         base_a_q <= '0;
         base_b_q <= '0;
      end else if (start) begin
         base_a_q <= op1_q;
         base_b_q <= op2_q;
      end else if (state_q == ST_PTR_CAP) begin
         if (!ptr_sel_q) begin
            base_a_q <= cmd_q[CMD_BCD] ? ptr_addr : mem_rdata;
         end else begin
            base_b_q <= cmd_q[CMD_BCD] ? ptr_addr : mem_rdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         a_val_q <= '0;
         b_val_q <= '0;
         hold_q <= '0;
         result_q <= '0;
      end else if (start) begin
         result_q <= '0;
      end else if (state_q == ST_CAPT) begin
         unique case (op_q)
            OP_SINGLE: begin
               if (step_q == 6'h00) begin
                  a_val_q <= {16'h0000, cap_data}; // see RQ19
               end else begin
                  b_val_q <= {16'h0000, cap_data}; // see RQ19
               end
            end
            OP_DOUBLE: begin
               unique case (step_q[1:0])
                  2'b00: a_val_q[15:0] <= cap_data; // see RQ4
                  2'b01: a_val_q[31:16] <= cap_data; // see RQ4
                  2'b10: b_val_q[15:0] <= cap_data; // see RQ4
                  2'b11: b_val_q[31:16] <= cap_data; // see RQ4
               endcase
            end
            OP_RANGE: begin
               if (step_q == 6'h00) begin
                  a_val_q <= {16'h0000, cap_data};
               end else if (step_q[0]) begin
                  hold_q <= cap_data;
               end else begin
                  // Every bit is written, so a miss leaves it off.
                  result_q[range_idx[3:0]] <= (a_val_q[15:0] >= hold_q) && (a_val_q[15:0] <= cap_data); // see RQ11, RQ12
               end
            end
            OP_TABLE: begin
               if (step_q == 6'h00) begin
                  a_val_q <= {16'h0000, cap_data};
               end else begin
                  result_q[table_idx[3:0]] <= (cap_data == a_val_q[15:0]); // see RQ16
               end
            end
            OP_PAIR: begin
               if (!step_q[0]) begin
                  hold_q <= cap_data;
               end else begin
                  result_q[step_q[4:1]] <= (hold_q != cap_data); // see RQ18
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         greater_flag <= 1'b0;
         equal_flag <= 1'b0;
         less_flag <= 1'b0;
         error_flag <= 1'b0;
      end else if (start) begin
         error_flag <= 1'b0;
      end else if (state_q == ST_PTR_CAP && cmd_q[CMD_BCD] && !ptr_ok) begin
         error_flag <= 1'b1; // see RQ2
      end else if (state_q == ST_DONE && !error_flag && (op_q == OP_SINGLE || op_q == OP_DOUBLE)) begin
         greater_flag <= cmp_gr; // see RQ1, RQ5
         equal_flag <= cmp_eq; // see RQ1, RQ5
         less_flag <= cmp_le; // see RQ1, RQ5
      end else if (state_q == ST_WRITE) begin
         equal_flag <= (result_q == 16'h0000); // see RQ15
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= '0;
      end else begin
         mem_rd <= (state_q == ST_PTR_RD) || (state_q == ST_FETCH && !imm_now);
         mem_wr <= (state_q == ST_WRITE);
         if (state_q == ST_PTR_RD) begin
            mem_addr <= ptr_sel_q ? op2_q : op1_q;
         end else if (state_q == ST_FETCH) begin
            mem_addr <= addr_of(op_q, step_q, base_a_q, base_b_q);
         end else if (state_q == ST_WRITE) begin
            mem_addr <= res_addr_q;
            mem_wdata <= result_q;
         end
      end
   end

   // An event in the cycle of a write-one-to-clear survives it.
   assign irq_evt = {(state_q == ST_PTR_CAP && cmd_q[CMD_BCD] && !ptr_ok), (state_q == ST_DONE)};

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == REG_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0)) | irq_evt;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (!reg_rd) begin
         reg_rdata <= '0;
      end else begin
         unique case (reg_addr)
            REG_CMD: reg_rdata <= {7'h00, cmd_q};
            REG_OP1: reg_rdata <= op1_q;
            REG_OP2: reg_rdata <= op2_q;
            REG_RES_ADDR: reg_rdata <= res_addr_q;
            REG_IMM1_LO: reg_rdata <= imm1_lo_q;
            REG_IMM1_HI: reg_rdata <= imm1_hi_q;
            REG_IMM2_LO: reg_rdata <= imm2_lo_q;
            REG_IMM2_HI: reg_rdata <= imm2_hi_q;
            REG_FLAGS: reg_rdata <= {11'h000, state_q != ST_IDLE, error_flag, less_flag, equal_flag, greater_flag};
            REG_RESULT: reg_rdata <= result_q;
            REG_IRQ_STAT: reg_rdata <= {14'h0000, irq_stat_q};
            REG_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask_q};
            default: reg_rdata <= '0;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   chk_flags_onehot: assert property ((state_q == ST_DONE && !error_flag && op_q inside {OP_SINGLE, OP_DOUBLE}) // see RQ5
      |=> $onehot({greater_flag, equal_flag, less_flag})) else $error("compare flags not one-hot");
   chk_single_greater: assert property ((state_q == ST_DONE && !error_flag && op_q == OP_SINGLE // see RQ1
      && a_val_q[15:0] > b_val_q[15:0]) |=> greater_flag && !less_flag) else $error("greater flag missed");
   chk_unsigned_order: assert property ((state_q == ST_DONE && !error_flag && op_q == OP_SINGLE // see RQ19
      && a_val_q[15] && !b_val_q[15]) |=> greater_flag) else $error("signed ordering used");
   chk_bcd_error: assert property ((state_q == ST_PTR_CAP && cmd_q[CMD_BCD] && !ptr_ok) // see RQ2
      |=> error_flag && state_q == ST_DONE ##1 state_q == ST_IDLE) else $error("bad pointer not flagged");
   chk_exec_off: assert property ((cmd_wr && !reg_wdata[CMD_EXEC] && state_q == ST_IDLE) // see RQ3
      |=> state_q == ST_IDLE && $stable(result_q) && $stable({greater_flag, equal_flag, less_flag, error_flag}))
      else $error("compare ran with condition off");
   chk_double_join: assert property ((state_q == ST_CAPT && op_q == OP_DOUBLE && step_q == 6'h01) // see RQ4
      |=> a_val_q[31:16] == $past(cap_data)) else $error("high half not from address plus one");
   chk_double_imm: assert property ((state_q == ST_CAPT && op_q == OP_DOUBLE && step_q == 6'h03 && cmd_q[CMD_IMM2]) // see RQ6
      |=> b_val_q[31:16] == imm2_hi_q && !mem_rd) else $error("immediate high half lost");
   chk_range_bit: assert property ((state_q == ST_CAPT && op_q == OP_RANGE && step_q == 6'h02) // see RQ11
      |=> result_q[0] == ($past(a_val_q[15:0]) >= $past(hold_q) && $past(a_val_q[15:0]) <= $past(cap_data)))
      else $error("range bit wrong");
   chk_range_clear: assert property ((start && norm_op(reg_wdata[2:0]) == OP_RANGE) // see RQ12
      |=> result_q == 16'h0000) else $error("stale range bits kept");
   chk_table_hit: assert property ((state_q == ST_CAPT && op_q == OP_TABLE && step_q == 6'h10) // see RQ16
      |=> result_q[15] == ($past(cap_data) == a_val_q[15:0])) else $error("table bit wrong");
   chk_pair_diff: assert property ((state_q == ST_CAPT && op_q == OP_PAIR && step_q == 6'h1f) // see RQ18
      |=> result_q[15] == ($past(hold_q) != $past(cap_data))) else $error("pair bit wrong");
   chk_zero_equal: assert property ((state_q == ST_WRITE) // see RQ15
      |=> equal_flag == (result_q == 16'h0000) && mem_wr && mem_wdata == result_q) else $error("zero result flag");
   chk_ni_alias: assert property ((start && reg_wdata[2:0] == OP_DOUBLE_NI) |=> op_q == OP_DOUBLE) // see RQ9
      else $error("non-intermediate opcode not mapped");

   cov_single: cover property (state_q == ST_DONE && op_q == OP_SINGLE);
   cov_range_hit: cover property (state_q == ST_WRITE && op_q == OP_RANGE && result_q != 16'h0000);
   cov_bcd_err: cover property (state_q == ST_PTR_CAP && cmd_q[CMD_BCD] && !ptr_ok);
   cov_irq: cover property (irq);

endmodule
